// file: rtl/adc_port_defines.vh
`ifndef ADC_PORT_DEFINES_VH
`define ADC_PORT_DEFINES_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 100
`define OUT_RATE_DHZ 166
`define SETTLE_US 120400
`define PWRUP_US 1000
`define PERIOD_CYC (`CLK_MHZ * 10000000 / `OUT_RATE_DHZ)
`define SETTLE_CYC (`SETTLE_US * `CLK_MHZ)
`define PWRUP_CYC (`PWRUP_US * `CLK_MHZ)
`define RESET_ONES 6'h20

// ----------------------------------------
// Communications word
// ----------------------------------------
`define CMD_BITS 6'h08
`define CMD_WEN 7
`define CMD_RS_HI 5
`define CMD_RS_LO 4
`define CMD_RW 3
`define CMD_CREAD 2
`define CMD_CREAD_EXIT 6'h0E
`define RS_STAT 2'h0
`define RS_MODE 2'h1
`define RS_DATA 2'h3

// ----------------------------------------
// Mode word
// ----------------------------------------
`define MODE_HI 7
`define MODE_LO 6
`define MODE_POL 2
`define MODE_RST 8'h02
`define MODE_CONT 2'h0
`define MODE_SINGLE 2'h2
`define MODE_PDOWN 2'h3

// ----------------------------------------
// Bus map
// ----------------------------------------
`define AXI_SAMPLE 4'h0
`define AXI_STATE 4'h4
`define AXI_DATA 4'h8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: rtl/adc_serial_port.v
// Contract
// - Results at fixed rate, two periods to settle.
// - After reset, await communications word first.
// - Communications word picks direction and register.
// - Ready low on result, high after read.
// - Ready rises before data register updates.
// - Select tied low gives three-wire operation.
// - Repeat reads allowed, except continuous read once.
// - Select fall presents MSB without clock edge.
// - Thirty-two ones reset interface and registers.
// - Single mode: power up, convert, power down.
// - Single mode: ready stays high after read.
// - Continuous mode default; completion clears ready bit.
// - Result discarded while data register read; the code discards it in continuous mode only.
// - Code 001111 enters continuous read mode.
// - Unread continuous-read result replaced by new.
// - Input watched for commands and reset.
// - Mode field: continuous, reserved, single, power-down.
// - Data register read-only, resets to zero.
// - Polarity set straight binary, clear offset.
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "adc_port_defines.vh"

module adc_serial_port #(
	parameter DATA_W = 24,
	parameter [31:0] PERIOD_CYC = `PERIOD_CYC,
	parameter [31:0] SETTLE_CYC = `SETTLE_CYC,
	parameter [31:0] PWRUP_CYC = `PWRUP_CYC
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write
	input wire [3:0] awaddr,
	input wire awvalid,
	output wire awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output wire wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	// AXI4-Lite read
	input wire [3:0] araddr,
	input wire arvalid,
	output wire arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	// Serial pins
	input wire cs_n,
	input wire sclk,
	input wire din,
	output reg dout_ff,
	output wire dout_oe
);

	localparam [1:0] ST_CMD = 2'h0;
	localparam [1:0] ST_WR = 2'h1;
	localparam [1:0] ST_RD = 2'h2;
	localparam [1:0] ST_CRD = 2'h3;
	localparam [5:0] DATA_LEN = DATA_W[5:0];

	wire s_cs_n;
	wire s_sclk;
	wire s_din;
	wire conv_done;
	wire rise;
	wire soft_rst;
	wire [7:0] cmd_word;
	wire [7:0] status_word;
	wire [DATA_W-1:0] coded;
	wire discard;
	reg sclk_d_ff;
	reg [1:0] state_ff;
	reg [7:0] in_sh_ff;
	reg [DATA_W-1:0] out_sh_ff;
	reg [5:0] bit_cnt_ff;
	reg [5:0] len_ff;
	reg [5:0] ones_ff;
	reg [7:0] mode_ff;
	reg [DATA_W-1:0] data_ff;
	reg rdy_n_ff;
	reg rd_data_ff;
	reg crd_busy_ff;
	reg upd_ff;
	reg restart_ff;
	reg [31:0] sample_ff;
	reg [3:0] awaddr_ff;
	reg got_aw_ff;
	reg [31:0] wdata_ff;
	reg [3:0] wstrb_ff;
	reg got_w_ff;

	// ----------------------------------------
	// Pin synchronisers and clock edges
	// ----------------------------------------
	pin_sync #(
		.W(3)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in({cs_n, sclk, din}),
		.pin_out({s_cs_n, s_sclk, s_din})
	);

	always @(posedge aclk) begin
		if (!aresetn) begin
			sclk_d_ff <= 1'b1;
		end else begin
			sclk_d_ff <= s_sclk;
		end
	end

	// Edges are only honoured while selected; a tied-low select works the same way.
	assign rise = s_sclk & ~sclk_d_ff & ~s_cs_n;
	assign soft_rst = rise & s_din & (ones_ff == (`RESET_ONES - 6'h01));
	assign cmd_word = {in_sh_ff[6:0], s_din};
	assign status_word = {rdy_n_ff, 5'h00, mode_ff[`MODE_HI:`MODE_LO]};

	// ----------------------------------------
	// Conversion timing
	// ----------------------------------------
	conv_seq #(
		.PERIOD_CYC(PERIOD_CYC),
		.SETTLE_CYC(SETTLE_CYC),
		.PWRUP_CYC(PWRUP_CYC)
	) u_conv (
		.aclk(aclk),
		.aresetn(aresetn),
		.restart(restart_ff),
		.mode(mode_ff[`MODE_HI:`MODE_LO]),
		.done_ff(conv_done)
	);

	// Software supplies the converted value as two's complement.
	assign coded = mode_ff[`MODE_POL] ? sample_ff[DATA_W-1:0] :
		{~sample_ff[DATA_W-1], sample_ff[DATA_W-2:0]};
	assign discard = (mode_ff[`MODE_HI:`MODE_LO] == `MODE_CONT) && (state_ff == ST_RD) && rd_data_ff;

	// ----------------------------------------
	// Serial engine and data register
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn || soft_rst) begin
			state_ff <= ST_CMD;
			in_sh_ff <= 8'h00;
			out_sh_ff <= {DATA_W{1'b0}};
			bit_cnt_ff <= 6'h00;
			len_ff <= 6'h00;
			ones_ff <= 6'h00;
			mode_ff <= `MODE_RST;
			data_ff <= {DATA_W{1'b0}};
			rdy_n_ff <= 1'b1;
			rd_data_ff <= 1'b0;
			crd_busy_ff <= 1'b0;
			upd_ff <= 1'b0;
			restart_ff <= soft_rst;
		end else begin
			restart_ff <= 1'b0;
			if (rise) begin
				ones_ff <= s_din ? ones_ff + 6'h01 : 6'h00;
				in_sh_ff <= cmd_word;
				case (state_ff)
					ST_CMD: begin
						bit_cnt_ff <= bit_cnt_ff + 6'h01;
						if (bit_cnt_ff == `CMD_BITS - 6'h01) begin
							bit_cnt_ff <= 6'h00;
							rd_data_ff <= 1'b0;
							if (!cmd_word[`CMD_WEN]) begin
								if (cmd_word[`CMD_RW]) begin
									state_ff <= ST_RD;
									len_ff <= 6'h08;
									out_sh_ff <= {status_word, {(DATA_W-8){1'b0}}};
									case (cmd_word[`CMD_RS_HI:`CMD_RS_LO])
										`RS_MODE: begin
											out_sh_ff <= {mode_ff, {(DATA_W-8){1'b0}}};
										end
										`RS_DATA: begin
											len_ff <= DATA_LEN;
											out_sh_ff <= data_ff;
											rd_data_ff <= 1'b1;
											if (cmd_word[`CMD_CREAD]) begin
												state_ff <= ST_CRD;
												crd_busy_ff <= 1'b0;
											end
										end
										default: begin
											len_ff <= 6'h08;
										end
									endcase
								end else if (cmd_word[`CMD_RS_HI:`CMD_RS_LO] == `RS_MODE) begin
									state_ff <= ST_WR;
									len_ff <= 6'h08;
								end
							end
						end
					end
					ST_WR: begin
						bit_cnt_ff <= bit_cnt_ff + 6'h01;
						if (bit_cnt_ff == len_ff - 6'h01) begin
							bit_cnt_ff <= 6'h00;
							state_ff <= ST_CMD;
							mode_ff <= cmd_word;
							restart_ff <= 1'b1;
						end
					end
					ST_RD: begin
						out_sh_ff <= {out_sh_ff[DATA_W-2:0], 1'b0};
						bit_cnt_ff <= bit_cnt_ff + 6'h01;
						if (bit_cnt_ff == len_ff - 6'h01) begin
							bit_cnt_ff <= 6'h00;
							state_ff <= ST_CMD;
							if (rd_data_ff) begin
								rdy_n_ff <= 1'b1;
							end
							rd_data_ff <= 1'b0;
						end
					end
					ST_CRD: begin
						// The input is watched for the exit word only while ready is low.
						if ((cmd_word[7:2] == `CMD_CREAD_EXIT) && !rdy_n_ff) begin
							state_ff <= ST_CMD;
							crd_busy_ff <= 1'b0;
							rd_data_ff <= 1'b0;
							bit_cnt_ff <= 6'h00;
						end else if (crd_busy_ff) begin
							out_sh_ff <= {out_sh_ff[DATA_W-2:0], 1'b0};
							bit_cnt_ff <= bit_cnt_ff + 6'h01;
							if (bit_cnt_ff == len_ff - 6'h01) begin
								bit_cnt_ff <= 6'h00;
								crd_busy_ff <= 1'b0;
								rdy_n_ff <= 1'b1;
							end
						end
					end
					default: begin
						state_ff <= ST_CMD;
					end
				endcase
			end
			// Placed last so a finished conversion wins over a read ending in the same cycle, except a continuous-mode data read, which discards it.
			if (conv_done) begin
				rdy_n_ff <= 1'b1;
				upd_ff <= 1'b1;
			end
			if (upd_ff) begin
				upd_ff <= 1'b0;
				if (!discard) begin
					data_ff <= coded;
					rdy_n_ff <= 1'b0;
					if (state_ff == ST_CRD) begin
						out_sh_ff <= coded;
						bit_cnt_ff <= 6'h00;
						crd_busy_ff <= 1'b1;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Data-out / ready pin
	// ----------------------------------------
	// The first bit is already at the top of the shifter, so a select fall shows it at once.
	always @(posedge aclk) begin
		if (!aresetn) begin
			dout_ff <= 1'b1;
		end else if ((state_ff == ST_RD) || ((state_ff == ST_CRD) && crd_busy_ff)) begin
			dout_ff <= out_sh_ff[DATA_W-1];
		end else begin
			dout_ff <= rdy_n_ff;
		end
	end

	assign dout_oe = ~s_cs_n;

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	assign awready = ~got_aw_ff;
	assign wready = ~got_w_ff;
	assign arready = ~rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_ff <= 4'h0;
			got_aw_ff <= 1'b0;
			wdata_ff <= 32'h0;
			wstrb_ff <= 4'h0;
			got_w_ff <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awaddr_ff <= awaddr;
				got_aw_ff <= 1'b1;
			end
			if (wvalid && wready) begin
				wdata_ff <= wdata;
				wstrb_ff <= wstrb;
				got_w_ff <= 1'b1;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
			if (got_aw_ff && got_w_ff && !bvalid) begin
				got_aw_ff <= 1'b0;
				got_w_ff <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (awaddr_ff == `AXI_SAMPLE) ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	genvar b;
	generate
		for (b = 0; b < 4; b = b + 1) begin : g_lane
			always @(posedge aclk) begin
				if (!aresetn) begin
					sample_ff[8*b+7:8*b] <= 8'h00;
				end else if (got_aw_ff && got_w_ff && !bvalid && (awaddr_ff == `AXI_SAMPLE) && wstrb_ff[b]) begin
					sample_ff[8*b+7:8*b] <= wdata_ff[8*b+7:8*b];
				end
			end
		end
	endgenerate

	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= `RESP_OKAY;
		end else begin
			if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rresp <= `RESP_OKAY;
				case (araddr)
					`AXI_SAMPLE: begin
						rdata <= sample_ff;
					end
					`AXI_STATE: begin
						rdata <= {16'h0000, mode_ff, 2'h0, crd_busy_ff, upd_ff, state_ff, rd_data_ff, rdy_n_ff};
					end
					`AXI_DATA: begin
						rdata <= {{(32-DATA_W){1'b0}}, data_ff};
					end
					default: begin
						rdata <= 32'h0;
						rresp <= `RESP_SLVERR;
					end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// file: rtl/conv_seq.v
`timescale 1ns/10ps
`default_nettype none
`include "adc_port_defines.vh"

module conv_seq #(
	parameter [31:0] PERIOD_CYC = `PERIOD_CYC,
	parameter [31:0] SETTLE_CYC = `SETTLE_CYC,
	parameter [31:0] PWRUP_CYC = `PWRUP_CYC
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Control
	input wire restart,
	input wire [1:0] mode,
	// Events
	output reg done_ff
);

	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_PWRUP = 2'h1;
	localparam [1:0] S_SETTLE = 2'h2;
	localparam [1:0] S_RUN = 2'h3;

	reg [1:0] state_ff;
	reg [31:0] cnt_ff;

	// ----------------------------------------
	// Conversion timing
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= S_SETTLE;
			cnt_ff <= SETTLE_CYC - 32'h1;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (restart) begin
				case (mode)
					`MODE_CONT: begin
						state_ff <= S_SETTLE;
						cnt_ff <= SETTLE_CYC - 32'h1;
					end
					`MODE_SINGLE: begin
						state_ff <= S_PWRUP;
						cnt_ff <= PWRUP_CYC - 32'h1;
					end
					default: begin
						state_ff <= S_IDLE;
						cnt_ff <= 32'h0;
					end
				endcase
			end else if (state_ff != S_IDLE) begin
				if (cnt_ff != 32'h0) begin
					cnt_ff <= cnt_ff - 32'h1;
				end else begin
					case (state_ff)
						S_PWRUP: begin
							state_ff <= S_SETTLE;
							cnt_ff <= SETTLE_CYC - 32'h1;
						end
						S_SETTLE, S_RUN: begin
							done_ff <= 1'b1;
							cnt_ff <= PERIOD_CYC - 32'h1;
							state_ff <= (mode == `MODE_CONT) ? S_RUN : S_IDLE;
						end
						default: begin
							state_ff <= S_IDLE;
						end
					endcase
				end
			end
		end
	end

endmodule

`default_nettype wire

// file: rtl/pin_sync.v
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
	parameter W = 3
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Pins
	input wire [W-1:0] pin_in,
	output wire [W-1:0] pin_out
);

	// ----------------------------------------
	// Two-stage synchroniser per bit
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg meta_ff;
			reg sync_ff;
			always @(posedge aclk) begin
				if (!aresetn) begin
					meta_ff <= 1'b1;
					sync_ff <= 1'b1;
				end else begin
					meta_ff <= pin_in[i];
					sync_ff <= meta_ff;
				end
			end
			assign pin_out[i] = sync_ff;
		end
	endgenerate

endmodule

`default_nettype wire

// file: sim/adc_port_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_port_defines.vh"
// ----
// Bus and pin checks
// ----
module adc_port_checker (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Bus
	input wire awvalid,
	input wire awready,
	input wire wvalid,
	input wire wready,
	input wire [1:0] bresp,
	input wire bvalid,
	input wire bready,
	input wire [3:0] araddr,
	input wire arvalid,
	input wire arready,
	input wire [31:0] rdata,
	input wire [1:0] rresp,
	input wire rvalid,
	input wire rready,
	// Pins
	input wire cs_n,
	input wire dout_oe
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_sel_low;
		!cs_n [*4];
	endsequence
	property p_wr_answer;
		s_wr_taken |-> ##[1:2] bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer missing");
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_b_drop;
		bvalid && bready |=> !bvalid;
	endproperty
	a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
	property p_rd_answer;
		arvalid && arready |=> rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer changed");
	property p_r_block;
		$rose(rvalid) |-> $past(arvalid) && $past(arready);
	endproperty
	a_r_block: assert property (p_r_block) else $error("read answer without request");
	property p_unmapped;
		arvalid && arready && araddr == 4'hC |=> rresp == `RESP_SLVERR && rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
	property p_oe_on;
		s_sel_low |-> dout_oe;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("pin not driven when selected");
	property p_oe_off;
		cs_n [*4] |-> !dout_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("pin driven when deselected");
endmodule
bind adc_serial_port adc_port_checker checker_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
	.rready(rready), .cs_n(cs_n), .dout_oe(dout_oe));
`default_nettype wire

// file: sim/adc_serial_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module adc_serial_port_tb;
	localparam int PER = 2000;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
	logic [31:0] wdata = 32'h0, d, q;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	wire awready, wready, bvalid, arready, rvalid, dout_ff, dout_oe, cs_n, sclk, din;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	// The pin has a pull-up, so a released line reads high.
	wire dout_pin = dout_oe ? dout_ff : 1'h1;
	logic [1:0] r;
	int fail_count = 0, n_checks = 0, cyc = 0;
	always #5 aclk = ~aclk;
	adc_serial_port #(.DATA_W(24), .PERIOD_CYC(PER), .SETTLE_CYC(2 * PER), .PWRUP_CYC(500)) adc_serial_port_i (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .cs_n(cs_n), .sclk(sclk), .din(din), .dout_ff(dout_ff), .dout_oe(dout_oe));
	serial_host serial_host_i (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout_pin));
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 80000) begin
			fail_count++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		// A late ready makes the slave hold its answer for one cycle.
		bready <= 1'h1;
		@(posedge aclk);
		r = bresp;
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rready <= 1'h1;
		@(posedge aclk);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask
	task automatic wait_rdy();
		do rd(4'h4); while (d[0] !== 1'h0);
	endtask
	task automatic setm(input logic [7:0] m);
		serial_host_i.xfer({8'h10, m, 16'h0}, 16, q);
	endtask
	task automatic getd();
		serial_host_i.xfer({8'h38, 24'h0}, 32, q);
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		rd(4'h8);
		chk(d, 32'h0);
		rd(4'h4);
		chk({24'h0, d[15:8]}, 32'h02);
		rd(4'hC);
		chk({30'h0, r}, 32'h2);
		wr(4'h8, 32'h1);
		chk({30'h0, r}, 32'h2);
		wr(4'h0, 32'h00123456);
		chk({30'h0, r}, 32'h0);
		$display("test registers done");
		wait_rdy();
		getd();
		chk({8'h0, q[23:0]}, 32'h923456);
		rd(4'h4);
		chk({31'h0, d[0]}, 32'h1);
		getd();
		chk({8'h0, q[23:0]}, 32'h923456);
		$display("test data read done");
		setm(8'h06);
		serial_host_i.xfer({8'h18, 24'h0}, 16, q);
		chk({24'h0, q[7:0]}, 32'h06);
		wait_rdy();
		getd();
		chk({8'h0, q[23:0]}, 32'h123456);
		serial_host_i.xfer({8'h38, 24'h0}, 8, q);
		serial_host_i.idle_clk(4);
		serial_host_i.xfer(32'h0, 24, q);
		chk({8'h0, q[23:0]}, 32'h123456);
		$display("test mode write done");
		serial_host_i.xfer({8'h3C, 24'h0}, 8, q);
		wait_rdy();
		serial_host_i.xfer(32'h0, 24, q);
		chk({8'h0, q[23:0]}, 32'h123456);
		rd(4'h4);
		chk({29'h0, d[3:2], d[0]}, 32'h7);
		wait_rdy();
		getd();
		rd(4'h4);
		chk({30'h0, d[3:2]}, 32'h0);
		$display("test continuous read done");
		serial_host_i.xfer(32'hFFFFFFFF, 32, q);
		serial_host_i.xfer({8'h18, 24'h0}, 16, q);
		chk({24'h0, q[7:0]}, 32'h02);
		$display("test soft reset done");
		setm(8'h86);
		wait_rdy();
		getd();
		chk({8'h0, q[23:0]}, 32'h123456);
		repeat (3 * PER) @(posedge aclk);
		rd(4'h4);
		chk({31'h0, d[0]}, 32'h1);
		for (int i = 0; i < 2; i++) begin
			setm(i == 0 ? 8'h46 : 8'hC6);
			repeat (3 * PER) @(posedge aclk);
			rd(4'h4);
			chk({31'h0, d[0]}, 32'h1);
		end
		setm(8'h06);
		wait_rdy();
		getd();
		chk({8'h0, q[23:0]}, 32'h123456);
		$display("test modes done");
		final_report();
	end
endmodule
`default_nettype wire

// file: sim/serial_host.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// Serial host
// ----
module serial_host (
	// Serial pins
	output var logic cs_n,
	output var logic sclk,
	output var logic din,
	input wire logic dout
);
	initial begin
		cs_n = 1'h1;
		sclk = 1'h1;
		din = 1'h0;
	end
	// The clock stands high between frames, so no stray rising edge reaches the port.
	task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
		rx = 32'h0;
		// Starting off the clock edge keeps the select change clear of the sampling flop.
		#2.5;
		cs_n = 1'h0;
		#62.5;
		for (int i = 0; i < n; i++) begin
			sclk = 1'h0;
			din = tx[31 - i];
			#62.5;
			sclk = 1'h1;
			rx = {rx[30:0], dout};
			#62.5;
		end
		din = 1'h0;
		cs_n = 1'h1;
		#125;
	endtask
	// A clock left running while select is high must not disturb the port.
	task automatic idle_clk(input int n);
		repeat (n) begin
			#62.5;
			sclk = 1'h0;
			#62.5;
			sclk = 1'h1;
		end
	endtask
endmodule
`default_nettype wire
